// file: inc/tcr_pkg.sv
// Package: addresses, bit layout and reset values of the timer register slice
package tcr_pkg;

  // ==========================================================
  // Address map (data-space addresses on the register port)
  // ==========================================================
  localparam logic [7:0] TCR_IO_TO_DATA_OFS = 8'h20;
  localparam logic [7:0] TCR_IO_SPACE_LAST = 8'h3F;
  localparam logic [7:0] TCR_EXT_IO_FIRST = 8'h60;
  localparam logic [7:0] TCR_FLAGS_IO = 8'h36;
  localparam logic [7:0] TCR_MASK_IO = 8'h37;
  localparam logic [7:0] TCR_FLAGS_ADDR = 8'(TCR_FLAGS_IO + TCR_IO_TO_DATA_OFS);
  localparam logic [7:0] TCR_MASK_ADDR = 8'(TCR_MASK_IO + TCR_IO_TO_DATA_OFS);
  localparam logic [7:0] TCR_FLAGS_EXT_ADDR = 8'h7C;
  localparam logic [7:0] TCR_MASK_EXT_ADDR = 8'h7D;
  localparam logic [7:0] TCR_CAP3_LOW_ADDR = 8'h80;
  localparam logic [7:0] TCR_CAP3_HIGH_ADDR = 8'h81;

  // ==========================================================
  // Field layout
  // ==========================================================
  // Timer 1 field in the shared flag and mask registers: bits 5..2
  localparam int TCR_T1_LSB = 2;
  localparam int TCR_T1_W = 4;
  // Extended registers: bits 5..0 implemented, 7..6 read zero
  localparam int TCR_EXT_W = 6;
  localparam int TCR_CAP_W = 16;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] TCR_MASK_RST = 8'h00;
  localparam logic [TCR_T1_W-1:0] TCR_T1_FLAGS_RST = 4'h0;
  localparam logic [TCR_EXT_W-1:0] TCR_EXT_RST = 6'h00;
  localparam logic [15:0] TCR_CAP_RST = 16'h0000;
  localparam logic [7:0] TCR_TEMP_RST = 8'h00;

endpackage : tcr_pkg

// file: design/tcr_regs.sv
// Timer capture register, shared byte latch and timer interrupt flag/mask
// Functional notes
// - Capture pin event copies counter into capture; timer 1 may use comparator.
// - Capture register may act as counter top, then events do not reload it.
// - Sixteen-bit capture accessed bytewise through an eight-bit holding byte.
// - One holding byte serves every sixteen-bit timer register in the device.
// - Timer 1 capture request = mask bit 5, global enable, capture flag.
// - Timer 1 compare A request = mask bit 4, global enable, flag.
// - Timer 1 compare B request = mask bit 3, global enable, flag.
// - Timer 1 overflow request = mask bit 2, global enable, flag.
// - Timer 3 capture request = extended mask bit 5, enable, flag.
// - Timer 3 compare A request = extended mask bit 4, enable, flag.
// - Timer 3 compare B request = extended mask bit 3, enable, flag.
// - Timer 3 overflow request = extended mask bit 2, enable, flag.
// - Timer 3 compare C request = extended mask bit 1, enable, flag.
// - Timer 1 compare C request = extended mask bit 0, enable, flag.
// - Extended mask register absent in legacy compatibility mode.
// - Shared mask register; timer 1 owns bits 5..2, reset zero.
// - Shared flag register; timer 1 owns bits 5..2, reset zero.
// - Flags clear on vector execution or when written with one.
// - Compare flag sets the cycle after the match; force never sets.
`timescale 1ns/1ps
module tcr_regs
  import tcr_pkg::*;
#(
  parameter int CAP_W = TCR_CAP_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port, data-space address
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Shared holding byte, other sixteen-bit registers
  input wire logic temp_load_en,
  input wire logic [7:0] temp_load_data,
  output logic [7:0] temp_value,
  // Core state
  input wire logic global_irq_en,
  input wire logic legacy_mode,
  // Timer 1 events
  input wire logic t1_capture_pin_evt,
  input wire logic analog_cmp_evt,
  input wire logic t1_capture_src_cmp,
  input wire logic t1_cmp_a_match,
  input wire logic t1_cmp_b_match,
  input wire logic t1_cmp_c_match,
  input wire logic t1_overflow_evt,
  // Timer 3 events and counter
  input wire logic capture_input_pin,
  input wire logic [CAP_W-1:0] counter_value,
  input wire logic t3_capture_is_top,
  input wire logic t3_top_reached,
  input wire logic t3_cmp_a_match,
  input wire logic t3_cmp_b_match,
  input wire logic t3_cmp_c_match,
  input wire logic t3_overflow_evt,
  // Vector executed acknowledges
  input wire logic [TCR_T1_W-1:0] t1_vec_ack,
  input wire logic [TCR_EXT_W-1:0] ext_vec_ack,
  // Outputs
  output logic [CAP_W-1:0] capture_top_value,
  output logic [7:0] timer_irq_mask,
  output logic [TCR_T1_W-1:0] t1_irq_req,
  output logic [TCR_EXT_W-1:0] ext_irq_req
);

  // ==========================================================
  // State
  // ==========================================================
  logic [7:0] mask_q, mask_d;
  logic [TCR_EXT_W-1:0] mask_ext_q, mask_ext_d;
  logic [TCR_T1_W-1:0] t1_flags_q, t1_flags_d;
  logic [TCR_EXT_W-1:0] ext_flags_q, ext_flags_d;
  logic [CAP_W-1:0] cap_q, cap_d;
  logic [7:0] temp_q, temp_d;
  logic [7:0] rdata_q, rdata_d;
  logic [TCR_T1_W-1:0] t1_set;
  logic [TCR_EXT_W-1:0] ext_set;
  logic [TCR_T1_W-1:0] t1_w1c;
  logic [TCR_EXT_W-1:0] ext_w1c;
  logic t3_cap_evt;
  logic wr_flags, wr_mask, wr_flags_ext, wr_mask_ext, wr_cap_lo, wr_cap_hi;
  logic rd_cap_lo, rd_cap_hi;

  // ==========================================================
  // Address decode
  // ==========================================================
  always_comb begin
    wr_flags = 1'b0;
    wr_mask = 1'b0;
    wr_flags_ext = 1'b0;
    wr_mask_ext = 1'b0;
    wr_cap_lo = 1'b0;
    wr_cap_hi = 1'b0;
    if (reg_addr == TCR_FLAGS_ADDR) begin
      wr_flags = reg_wr_en;
    end else if (reg_addr == TCR_MASK_ADDR) begin
      wr_mask = reg_wr_en;
    end else if (reg_addr == TCR_FLAGS_EXT_ADDR) begin
      wr_flags_ext = reg_wr_en;
    end else if (reg_addr == TCR_MASK_EXT_ADDR) begin
      wr_mask_ext = reg_wr_en && !legacy_mode;
    end else if (reg_addr == TCR_CAP3_LOW_ADDR) begin
      wr_cap_lo = reg_wr_en;
    end else if (reg_addr == TCR_CAP3_HIGH_ADDR) begin
      wr_cap_hi = reg_wr_en;
    end
  end

  assign rd_cap_lo = reg_rd_en && (reg_addr == TCR_CAP3_LOW_ADDR);
  assign rd_cap_hi = reg_rd_en && (reg_addr == TCR_CAP3_HIGH_ADDR);

  // ==========================================================
  // Event sources
  // ==========================================================
  // Order cap, cmp A, cmp B, overflow matches register bits 5..2.
  // Force strobes are not routed here, so they never set a flag.
  always_comb begin
    t1_set = {t1_capture_src_cmp ? analog_cmp_evt : t1_capture_pin_evt,
              t1_cmp_a_match, t1_cmp_b_match, t1_overflow_evt};
  end

  // In top mode the pin no longer captures; reaching top sets the flag
  assign t3_cap_evt = t3_capture_is_top ? t3_top_reached
                                        : capture_input_pin;

  assign ext_set = {t3_cap_evt, t3_cmp_a_match, t3_cmp_b_match,
                    t3_overflow_evt, t3_cmp_c_match, t1_cmp_c_match};

  assign t1_w1c = wr_flags ? reg_wdata[TCR_T1_LSB +: TCR_T1_W]
                           : {TCR_T1_W{1'b0}};
  assign ext_w1c = wr_flags_ext ? reg_wdata[TCR_EXT_W-1:0]
                                : {TCR_EXT_W{1'b0}};

  // ==========================================================
  // Flags and masks
  // ==========================================================
  // Set wins over a clear arriving in the same cycle
  always_comb begin
    t1_flags_d = (t1_flags_q & ~(t1_w1c | t1_vec_ack)) | t1_set;
    ext_flags_d = (ext_flags_q & ~(ext_w1c | ext_vec_ack)) | ext_set;
    mask_d = wr_mask ? reg_wdata : mask_q;
    mask_ext_d = wr_mask_ext ? reg_wdata[TCR_EXT_W-1:0]
                             : mask_ext_q;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      t1_flags_q <= TCR_T1_FLAGS_RST;
      ext_flags_q <= TCR_EXT_RST;
      mask_q <= TCR_MASK_RST;
      mask_ext_q <= TCR_EXT_RST;
    end else begin
      t1_flags_q <= t1_flags_d;
      ext_flags_q <= ext_flags_d;
      mask_q <= mask_d;
      mask_ext_q <= mask_ext_d;
    end
  end

  // ==========================================================
  // Capture register and shared holding byte
  // ==========================================================
  // Low read latches the high byte; high write parks in the holding
  // byte and the low write commits both halves in one edge.
  always_comb begin
    cap_d = cap_q;
    temp_d = temp_q;
    if (wr_cap_lo) begin
      cap_d = {temp_q, reg_wdata};
    end else if (t3_cap_evt && !t3_capture_is_top) begin
      cap_d = counter_value;
    end
    if (rd_cap_lo) begin
      temp_d = cap_q[CAP_W-1:8];
    end else if (wr_cap_hi) begin
      temp_d = reg_wdata;
    end else if (temp_load_en) begin
      temp_d = temp_load_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cap_q <= TCR_CAP_RST;
      temp_q <= TCR_TEMP_RST;
    end else begin
      cap_q <= cap_d;
      temp_q <= temp_d;
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  // Unmapped and absent addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (!reg_rd_en) begin
      rdata_d = rdata_q;
    end else if (reg_addr == TCR_FLAGS_ADDR) begin
      rdata_d[TCR_T1_LSB +: TCR_T1_W] = t1_flags_q;
    end else if (reg_addr == TCR_MASK_ADDR) begin
      rdata_d = mask_q;
    end else if (reg_addr == TCR_FLAGS_EXT_ADDR) begin
      rdata_d[TCR_EXT_W-1:0] = ext_flags_q;
    end else if (reg_addr == TCR_MASK_EXT_ADDR && !legacy_mode) begin
      rdata_d[TCR_EXT_W-1:0] = mask_ext_q;
    end else if (rd_cap_lo) begin
      rdata_d = cap_q[7:0];
    end else if (rd_cap_hi) begin
      rdata_d = temp_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  logic [TCR_EXT_W-1:0] mask_ext_eff;
  assign mask_ext_eff = legacy_mode ? TCR_EXT_RST : mask_ext_q;

  // Bits 3..0: capture, cmp A, cmp B, overflow
  assign t1_irq_req = mask_q[TCR_T1_LSB +: TCR_T1_W] & t1_flags_q
                      & {TCR_T1_W{global_irq_en}};
  // Bits 5..0: t3 cap, t3 A, t3 B, t3 ovf, t3 C, t1 C
  assign ext_irq_req = mask_ext_eff & ext_flags_q
                       & {TCR_EXT_W{global_irq_en}};

  assign reg_rdata = rdata_q;
  assign temp_value = temp_q;
  assign capture_top_value = cap_q;
  assign timer_irq_mask = mask_q;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_cap_load;
    capture_input_pin && !t3_capture_is_top && !wr_cap_lo
      |=> cap_q == $past(counter_value);
  endproperty
  a_cap_load: assert property (p_cap_load)
    else $error("capture did not load counter");

  property p_top_hold;
    t3_capture_is_top && !wr_cap_lo |=> $stable(cap_q);
  endproperty
  a_top_hold: assert property (p_top_hold)
    else $error("capture changed while used as top");

  property p_atomic;
    wr_cap_hi ##1 (wr_cap_lo && !temp_load_en)
      |=> cap_q == {$past(reg_wdata, 2), $past(reg_wdata)};
  endproperty
  a_atomic: assert property (p_atomic)
    else $error("capture pair write not atomic");

  property p_lo_latch;
    rd_cap_lo ##1 rd_cap_hi |=> reg_rdata == $past(cap_q[15:8], 2);
  endproperty
  a_lo_latch: assert property (p_lo_latch)
    else $error("high byte not from low read latch");

  property p_shared;
    temp_load_en && !rd_cap_lo && !wr_cap_hi
      |=> temp_value == $past(temp_load_data);
  endproperty
  a_shared: assert property (p_shared)
    else $error("holding byte not shared");

  property p_t1_irq;
    t1_irq_req[3] == (mask_q[5] && global_irq_en && t1_flags_q[3]);
  endproperty
  a_t1_irq: assert property (p_t1_irq)
    else $error("timer 1 capture request wrong");

  // A mask write in the same cycle may legally drop the enable
  property p_t1_ovf;
    t1_overflow_evt && global_irq_en && mask_q[2] && !wr_mask
      |=> (global_irq_en |-> t1_irq_req[0]);
  endproperty
  a_t1_ovf: assert property (p_t1_ovf)
    else $error("overflow request missing");

  property p_ext_irq;
    ext_irq_req == (mask_ext_q & ext_flags_q & {6{global_irq_en}}
                    & {6{!legacy_mode}});
  endproperty
  a_ext_irq: assert property (p_ext_irq)
    else $error("extended request wrong");

  property p_legacy;
    legacy_mode && reg_rd_en && reg_addr == TCR_MASK_EXT_ADDR
      |=> reg_rdata == 8'h00;
  endproperty
  a_legacy: assert property (p_legacy)
    else $error("extended mask visible in legacy mode");

  property p_w1c;
    wr_flags && reg_wdata[4] && !t1_cmp_a_match |=> !t1_flags_q[2];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear flag");

  property p_set_wins;
    t1_cmp_b_match |=> t1_flags_q[1];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("match did not set flag next cycle");

  property p_ext_top;
    reg_rd_en && reg_addr == TCR_MASK_EXT_ADDR
      |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_ext_top: assert property (p_ext_top)
    else $error("extended mask high bits not zero");

  c_capture: cover property (capture_input_pin ##[1:4] rd_cap_lo
                             ##[1:4] rd_cap_hi);
  c_pair_wr: cover property (wr_cap_hi ##1 wr_cap_lo);
  c_irq: cover property (t1_cmp_a_match ##1 t1_irq_req[2]);
  c_race: cover property (wr_flags_ext && reg_wdata[5] && t3_cap_evt);

endmodule : tcr_regs

// file: verif/tcr_regs_bench.sv
// Self-checking bench for the timer capture and interrupt register slice
`timescale 1ns/1ps
module tcr_regs_bench;
  import tcr_pkg::*;

  // ==========================================================
  // Stimulus and observed signals
  // ==========================================================
  logic ref_clk, rst, wr_en, rd_en, tl_en, gie, legacy, src_cmp, is_top;
  logic [7:0] addr, wdata, rdata, tl_data, temp_value, mask;
  logic [11:0] ev;
  logic [15:0] cnt, cap;
  logic [3:0] t1_ack, t1_req;
  logic [5:0] ext_ack, ext_req;
  logic [7:0] ra [7];
  int n_mismatch, cmp_count;

  tcr_regs uut (
    .ref_clk(ref_clk), .rst(rst),
    .reg_addr(addr), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_wdata(wdata), .reg_rdata(rdata),
    .temp_load_en(tl_en), .temp_load_data(tl_data), .temp_value(temp_value),
    .global_irq_en(gie), .legacy_mode(legacy),
    .t1_capture_pin_evt(ev[0]), .analog_cmp_evt(ev[10]),
    .t1_capture_src_cmp(src_cmp), .t1_cmp_a_match(ev[1]),
    .t1_cmp_b_match(ev[2]), .t1_cmp_c_match(ev[9]),
    .t1_overflow_evt(ev[3]), .capture_input_pin(ev[4]),
    .counter_value(cnt), .t3_capture_is_top(is_top),
    .t3_top_reached(ev[11]), .t3_cmp_a_match(ev[5]),
    .t3_cmp_b_match(ev[6]), .t3_cmp_c_match(ev[8]),
    .t3_overflow_evt(ev[7]), .t1_vec_ack(t1_ack), .ext_vec_ack(ext_ack),
    .capture_top_value(cap), .timer_irq_mask(mask),
    .t1_irq_req(t1_req), .ext_irq_req(ext_req)
  );

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  // Read data is registered on the taking edge and checked just after it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask : rd

  // Back-to-back byte pair, high first on write and low first on read
  task automatic cap_pair(input logic is_wr, input logic [15:0] v);
    @(posedge ref_clk);
    addr <= is_wr ? TCR_CAP3_HIGH_ADDR : TCR_CAP3_LOW_ADDR;
    wdata <= v[15:8];
    wr_en <= is_wr;
    rd_en <= !is_wr;
    @(posedge ref_clk);
    addr <= is_wr ? TCR_CAP3_LOW_ADDR : TCR_CAP3_HIGH_ADDR;
    wdata <= v[7:0];
    #1;
    if (!is_wr) chk({8'h00, rdata}, {8'h00, v[7:0]});
    @(posedge ref_clk);
    {wr_en, rd_en} <= 2'b00;
    #1;
    if (!is_wr) chk({8'h00, rdata}, {8'h00, v[15:8]});
  endtask : cap_pair

  task automatic pulse(input int i);
    @(posedge ref_clk);
    ev[i] <= 1'b1;
    @(posedge ref_clk);
    ev[i] <= 1'b0;
    #1;
  endtask : pulse

  task automatic ack(input int i);
    @(posedge ref_clk);
    if (i < 4) t1_ack <= 4'h8 >> i;
    else ext_ack <= 6'h20 >> (i - 4);
    @(posedge ref_clk);
    t1_ack <= 4'h0;
    ext_ack <= 6'h00;
    #1;
  endtask : ack

  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Clock and watchdog
  // ==========================================================
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    rst = 1'b1;
    {wr_en, rd_en, tl_en, gie, legacy, src_cmp, is_top} = 7'h00;
    {addr, wdata, tl_data} = 24'h0000_00;
    ev = 12'h000;
    cnt = 16'h0000;
    t1_ack = 4'h0;
    ext_ack = 6'h00;
    ra = '{TCR_FLAGS_ADDR, TCR_MASK_ADDR, TCR_FLAGS_EXT_ADDR,
      TCR_MASK_EXT_ADDR, TCR_CAP3_LOW_ADDR, TCR_CAP3_HIGH_ADDR, 8'h40};
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (ra[k]) rd(ra[k], 8'h00);
    wr(TCR_MASK_ADDR, 8'hff);
    rd(TCR_MASK_ADDR, 8'hff);
    chk({8'h00, mask}, 16'h00ff);
    wr(TCR_MASK_EXT_ADDR, 8'hff);
    rd(TCR_MASK_EXT_ADDR, 8'h3f);
    @(posedge ref_clk);
    legacy <= 1'b1;
    rd(TCR_MASK_EXT_ADDR, 8'h00);
    wr(TCR_MASK_EXT_ADDR, 8'h00);
    @(posedge ref_clk);
    legacy <= 1'b0;
    gie <= 1'b1;
    rd(TCR_MASK_EXT_ADDR, 8'h3f);
    // Every flag: set, request, gating, then clear
    for (int i = 0; i < 10; i++) begin
      pulse(i);
      if (i < 4) begin
        chk({12'h000, t1_req}, 16'h0008 >> i);
        rd(TCR_FLAGS_ADDR, 8'h20 >> i);
        @(posedge ref_clk);
        gie <= 1'b0;
        #1;
        chk({12'h000, t1_req}, 16'h0000);
        gie <= 1'b1;
        wr(TCR_MASK_ADDR, 8'h00);
        chk({12'h000, t1_req}, 16'h0000);
        wr(TCR_MASK_ADDR, 8'hff);
      end else begin
        chk({10'h000, ext_req}, 16'h0020 >> (i - 4));
        rd(TCR_FLAGS_EXT_ADDR, 8'h20 >> (i - 4));
        @(posedge ref_clk);
        legacy <= 1'b1;
        #1;
        chk({10'h000, ext_req}, 16'h0000);
        legacy <= 1'b0;
        wr(TCR_MASK_EXT_ADDR, 8'h00);
        chk({10'h000, ext_req}, 16'h0000);
        wr(TCR_MASK_EXT_ADDR, 8'hff);
      end
      if (i % 2 == 1) ack(i);
      else if (i < 4) wr(TCR_FLAGS_ADDR, 8'h20 >> i);
      else wr(TCR_FLAGS_EXT_ADDR, 8'h20 >> (i - 4));
      chk({6'h00, t1_req, ext_req}, 16'h0000);
    end
    // Clear by write and capture event in one cycle: set must win
    @(posedge ref_clk);
    addr <= TCR_FLAGS_EXT_ADDR;
    wdata <= 8'h20;
    wr_en <= 1'b1;
    ev[4] <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    ev[4] <= 1'b0;
    #1;
    chk({10'h000, ext_req}, 16'h0020);
    // Capture of the counter and atomic byte access
    @(posedge ref_clk);
    cnt <= 16'ha5c3;
    pulse(4);
    chk(cap, 16'ha5c3);
    rd(TCR_CAP3_LOW_ADDR, 8'hc3);
    chk({8'h00, temp_value}, 16'h00a5);
    rd(TCR_CAP3_HIGH_ADDR, 8'ha5);
    ack(4);
    cap_pair(1'b1, 16'h5678);
    chk(cap, 16'h5678);
    cap_pair(1'b0, 16'h5678);
    wr(TCR_CAP3_HIGH_ADDR, 8'h12);
    wr(TCR_CAP3_LOW_ADDR, 8'h34);
    chk(cap, 16'h1234);
    // Holding byte loaded by another sixteen-bit register
    @(posedge ref_clk);
    tl_en <= 1'b1;
    tl_data <= 8'h5a;
    @(posedge ref_clk);
    tl_en <= 1'b0;
    #1;
    chk({8'h00, temp_value}, 16'h005a);
    rd(TCR_CAP3_HIGH_ADDR, 8'h5a);
    // Capture register as counter top: pin no longer loads it
    @(posedge ref_clk);
    is_top <= 1'b1;
    cnt <= 16'hbeef;
    pulse(4);
    chk(cap, 16'h1234);
    ack(4);
    pulse(11);
    chk({10'h000, ext_req}, 16'h0020);
    // Comparator as timer 1 capture source
    @(posedge ref_clk);
    src_cmp <= 1'b1;
    pulse(10);
    chk({12'h000, t1_req}, 16'h0008);
    print_verdict();
  end
endmodule : tcr_regs_bench
